/* File: core/dupc_top.sv */
// dupc_top: pin straps, reset handling and channel b receive routing
`timescale 1ns/100ps
module dupc_top
	import dupc_pkg::*;
#(
	parameter int FIFO_DEPTH = FIFO_BYTES,
	parameter int STAGE_WORDS = STAGE_DEPTH
) (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic bus_style_select_in,
	input wire logic hw_reset_pin_in,
	input wire logic rx_b_source_select_in,
	input wire logic rx_b_logic_input_in,
	input wire logic rx_b_line_input_in,
	input wire logic rate_select_in,
	input wire logic bus_isolate_request_in,
	input wire logic sleep_mode_in,
	input wire logic prescale_select_in,
	input wire logic [15:0] baud_div_in,
	input wire logic [3:0] baud_frac_in,
	input wire logic host_wr_in,
	input wire logic host_rd_in,
	input wire logic [7:0] host_wr_data_in,
	input wire logic tx_a_internal_in,
	input wire logic tx_b_internal_in,
	input wire logic rx_stage_ready_in,
	output logic bus_style_strobe_out,
	output logic uart_reset_n_out,
	output logic tx_a_line_output_out,
	output logic tx_b_logic_output_out,
	output logic tx_b_line_output_out,
	output logic rx_b_selected_out,
	output logic [7:0] min_bit_cycles_out,
	output logic [6:0] fifo_depth_out,
	output logic bus_isolated_out,
	output logic host_wr_out,
	output logic host_rd_out,
	output logic wr_stage_ready_out,
	output logic [7:0] rx_stage_data_out,
	output logic rx_stage_valid_out,
	output logic baud_tick_out
);
	initial begin
		if (FIFO_DEPTH != FIFO_BYTES) $error("fifo depth must be 64 bytes");
		if (STAGE_WORDS < 2) $error("stage depth too small");
	end

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [1:0] style_s_q;
	logic [1:0] rstpin_s_q;
	logic [1:0] rxsel_s_q;
	logic [1:0] rxl_s_q;
	logic [1:0] rxn_s_q;
	logic [1:0] rate_s_q;
	logic [1:0] iso_s_q;

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			style_s_q <= '0;
			rstpin_s_q <= '0;
			rxsel_s_q <= '0;
			rxl_s_q <= '0;
			rxn_s_q <= '0;
			rate_s_q <= '0;
			iso_s_q <= '0;
		end else begin
			style_s_q <= {style_s_q[0], bus_style_select_in};
			rstpin_s_q <= {rstpin_s_q[0], hw_reset_pin_in};
			rxsel_s_q <= {rxsel_s_q[0], rx_b_source_select_in};
			rxl_s_q <= {rxl_s_q[0], rx_b_logic_input_in};
			rxn_s_q <= {rxn_s_q[0], rx_b_line_input_in};
			rate_s_q <= {rate_s_q[0], rate_select_in};
			iso_s_q <= {iso_s_q[0], bus_isolate_request_in};
		end
	end

	// ----------------------------------------------------------------
	// reset pin polarity and width qualification
	// ----------------------------------------------------------------
	dupc_bus_style_t style_w;
	logic pin_active_w;
	logic [3:0] pulse_cnt_q;
	logic pin_reset_q;
	assign style_w = style_s_q[1] ? DUPC_BUS_STROBE : DUPC_BUS_RWSEL;
	// strobe style uses active high, read/write-select active low
	assign pin_active_w = (style_w == DUPC_BUS_STROBE) ? rstpin_s_q[1] : !rstpin_s_q[1];

	// pulses shorter than the minimum width are ignored
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pulse_cnt_q <= '0;
			pin_reset_q <= 1'b0;
		end else if (!pin_active_w) begin
			pulse_cnt_q <= '0;
			pin_reset_q <= 1'b0;
		end else if (pulse_cnt_q < 4'(RST_MIN_CYCLES)) begin
			pulse_cnt_q <= pulse_cnt_q + 4'h1;
		end else begin
			pin_reset_q <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// internal reset: async assert, synchronised release
	// ----------------------------------------------------------------
	logic int_rst_n_w;
	logic [1:0] rst_sync_q;
	assign int_rst_n_w = rst_n_in && !pin_reset_q;

	always_ff @(posedge core_clk_in or negedge int_rst_n_w) begin
		if (!int_rst_n_w) begin
			rst_sync_q <= '0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end

	logic rst_n;
	assign rst_n = rst_sync_q[1];

	// ----------------------------------------------------------------
	// straps and serial pins
	// ----------------------------------------------------------------
	logic rx_b_q;
	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			uart_reset_n_out <= 1'b0;
			bus_style_strobe_out <= 1'b0;
			tx_a_line_output_out <= TX_IDLE;
			tx_b_logic_output_out <= TX_IDLE;
			tx_b_line_output_out <= TX_IDLE;
			rx_b_q <= TX_IDLE;
			min_bit_cycles_out <= MIN_BIT_CYC_SLOW;
			fifo_depth_out <= '0;
		end else begin
			uart_reset_n_out <= 1'b1;
			bus_style_strobe_out <= (style_w == DUPC_BUS_STROBE);
			tx_a_line_output_out <= tx_a_internal_in;
			tx_b_logic_output_out <= tx_b_internal_in;
			tx_b_line_output_out <= tx_b_internal_in;
			rx_b_q <= rxsel_s_q[1] ? rxl_s_q[1] : rxn_s_q[1];
			min_bit_cycles_out <= rate_s_q[1] ? MIN_BIT_CYC_FAST : MIN_BIT_CYC_SLOW;
			fifo_depth_out <= 7'(FIFO_DEPTH);
		end
	end
	assign rx_b_selected_out = rx_b_q;

	// ----------------------------------------------------------------
	// host bus isolation
	// ----------------------------------------------------------------
	logic iso_w;
	assign iso_w = iso_s_q[1] && sleep_mode_in;
	logic stg_in_ready;
	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			bus_isolated_out <= 1'b0;
			host_wr_out <= 1'b0;
			host_rd_out <= 1'b0;
			wr_stage_ready_out <= 1'b0;
		end else begin
			bus_isolated_out <= iso_w;
			host_wr_out <= host_wr_in && !iso_w;
			host_rd_out <= host_rd_in && !iso_w;
			// registered status, lags the fifo's own refusal by one cycle
			wr_stage_ready_out <= stg_in_ready;
		end
	end

	// ----------------------------------------------------------------
	// write data staging fifo, back-pressure to the host side
	// ----------------------------------------------------------------
	dupc_fifo #(.WIDTH(8), .DEPTH(STAGE_WORDS)) u_stage (
		.core_clk_in(core_clk_in),
		.rst_n_in(rst_n),
		.in_valid_in(host_wr_in && !iso_w),
		.in_ready_out(stg_in_ready),
		.in_data_in(host_wr_data_in),
		.out_valid_out(rx_stage_valid_out),
		.out_ready_in(rx_stage_ready_in),
		.out_data_out(rx_stage_data_out)
	);

	// ----------------------------------------------------------------
	// baud generator: prescaler then fractional divider
	// ----------------------------------------------------------------
	logic [2:0] pre_cnt_q;
	logic pre_tick_w;
	logic [15:0] div_cnt_q;
	logic [FRAC_BITS-1:0] frac_acc_q;
	logic [FRAC_BITS:0] frac_sum_w;
	assign pre_tick_w = (pre_cnt_q == 3'h0);
	assign frac_sum_w = {1'b0, frac_acc_q} + {1'b0, baud_frac_in};

	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			pre_cnt_q <= '0;
		end else if (pre_tick_w) begin
			pre_cnt_q <= (prescale_select_in ? PRESCALE_HIGH : PRESCALE_LOW) - 3'h1;
		end else begin
			pre_cnt_q <= pre_cnt_q - 3'h1;
		end
	end

	// fractional part stretches one period by one prescaler tick on carry
	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt_q <= DIV_RESET;
			frac_acc_q <= FRAC_RESET;
			baud_tick_out <= 1'b0;
		end else begin
			baud_tick_out <= 1'b0;
			if (pre_tick_w) begin
				if (div_cnt_q <= 16'h0001) begin
					baud_tick_out <= 1'b1;
					frac_acc_q <= frac_sum_w[FRAC_BITS-1:0];
					div_cnt_q <= (baud_div_in == 16'h0000) ? DIV_RESET :
						baud_div_in + {15'h0000, frac_sum_w[FRAC_BITS]};
				end else begin
					div_cnt_q <= div_cnt_q - 16'h0001;
				end
			end
		end
	end
endmodule // dupc_top

/* File: core/dupc_pkg.sv */
// dupc_pkg: constants for the dual uart pin configuration and reset block
package dupc_pkg;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 25000;
	localparam int RST_MIN_PULSE_PS = 40000;
	// least time rounds up, never below one cycle
	localparam int RST_MIN_CYCLES_RAW = (RST_MIN_PULSE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int RST_MIN_CYCLES = (RST_MIN_CYCLES_RAW < 1) ? 1 : RST_MIN_CYCLES_RAW;
	// ----------------------------------------------------------------
	// line rate limits
	// ----------------------------------------------------------------
	localparam int RATE_FAST_BPS = 1000000;
	localparam int RATE_SLOW_BPS = 250000;
	localparam int CLK_HZ = 40000000;
	// fewest clock cycles per bit for each limit
	localparam logic [7:0] MIN_BIT_CYC_FAST = 8'(CLK_HZ / RATE_FAST_BPS);
	localparam logic [7:0] MIN_BIT_CYC_SLOW = 8'(CLK_HZ / RATE_SLOW_BPS);
	// ----------------------------------------------------------------
	// fifo and prescaler
	// ----------------------------------------------------------------
	localparam int FIFO_BYTES = 64;
	localparam int STAGE_DEPTH = 8;
	localparam logic [2:0] PRESCALE_LOW = 3'h1;
	localparam logic [2:0] PRESCALE_HIGH = 3'h4;
	localparam int FRAC_BITS = 4;
	localparam logic [15:0] DIV_RESET = 16'h0001;
	localparam logic [3:0] FRAC_RESET = 4'h0;
	localparam logic TX_IDLE = 1'b1;
	typedef enum logic {DUPC_BUS_RWSEL, DUPC_BUS_STROBE} dupc_bus_style_t;
endpackage

/* File: core/dupc_fifo.sv */
// dupc_fifo: parameterised valid/ready fifo with registered read data
`timescale 1ns/100ps
module dupc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	localparam int AW = $clog2(DEPTH);
	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be a power of two");
	end
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0] wr_q;
	logic [AW:0] rd_q;
	logic full_w;
	logic empty_w;
	logic push_w;
	logic pop_w;
	logic [AW:0] used_w;
	// the output register is one of the DEPTH words, so it counts as used
	assign used_w = (wr_q - rd_q) + {{AW{1'b0}}, out_valid_out};
	assign full_w = (used_w == (AW+1)'(DEPTH));
	assign empty_w = (wr_q == rd_q);
	assign push_w = in_valid_in && !full_w;
	// output register reloads when empty or being taken
	assign pop_w = !empty_w && (!out_valid_out || out_ready_in);
	assign in_ready_out = !full_w;

	always_ff @(posedge core_clk_in) begin
		if (push_w) begin
			mem_q[wr_q[AW-1:0]] <= in_data_in;
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push_w) wr_q <= wr_q + 1'b1;
			if (pop_w) rd_q <= rd_q + 1'b1;
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			out_valid_out <= 1'b0;
			out_data_out <= '0;
		end else if (pop_w) begin
			out_valid_out <= 1'b1;
			out_data_out <= mem_q[rd_q[AW-1:0]];
		end else if (out_ready_in) begin
			out_valid_out <= 1'b0;
		end
	end
endmodule // dupc_fifo

/* File: tb/dupc_props.sv */
// dupc_props: concurrent checks on the pin strap and reset block
`timescale 1ns/100ps
module dupc_props
	import dupc_pkg::*;
(
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic bus_style_select_in,
	input wire logic hw_reset_pin_in,
	input wire logic rx_b_source_select_in,
	input wire logic rx_b_logic_input_in,
	input wire logic rx_b_line_input_in,
	input wire logic rate_select_in,
	input wire logic bus_isolate_request_in,
	input wire logic sleep_mode_in,
	input wire logic host_wr_in,
	input wire logic host_rd_in,
	input wire logic tx_a_internal_in,
	input wire logic tx_b_internal_in,
	input wire logic bus_style_strobe_out,
	input wire logic uart_reset_n_out,
	input wire logic host_wr_out,
	input wire logic host_rd_out,
	input wire logic tx_a_line_output_out,
	input wire logic tx_b_logic_output_out,
	input wire logic tx_b_line_output_out,
	input wire logic rx_b_selected_out,
	input wire logic bus_isolated_out,
	input wire logic [7:0] min_bit_cycles_out,
	input wire logic [6:0] fifo_depth_out
);
	// ----
	// properties
	// ----
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);
	// pin level equal to the style level means active
	AST_PIN_RESET: assert property (
		(hw_reset_pin_in == bus_style_select_in)[*8] |-> !uart_reset_n_out)
		else $error("pin reset ignored");
	AST_TX_RESET: assert property (
		!uart_reset_n_out |-> rx_b_selected_out && tx_a_line_output_out &&
		tx_b_logic_output_out && tx_b_line_output_out)
		else $error("outputs not at reset level");
	AST_TX_FOLLOW: assert property (
		uart_reset_n_out && $past(uart_reset_n_out) |->
		tx_a_line_output_out == $past(tx_a_internal_in) &&
		tx_b_logic_output_out == $past(tx_b_internal_in) &&
		tx_b_line_output_out == $past(tx_b_internal_in))
		else $error("tx outputs do not follow");
	AST_STYLE: assert property (
		$stable(bus_style_select_in)[*5] ##0 (uart_reset_n_out && $past(uart_reset_n_out, 3))
		|-> bus_style_strobe_out == bus_style_select_in)
		else $error("bus style wrong");
	AST_RX_SEL: assert property (
		$stable({rx_b_source_select_in, rx_b_logic_input_in, rx_b_line_input_in})[*5]
		##0 (uart_reset_n_out && $past(uart_reset_n_out, 3)) |-> rx_b_selected_out ==
		(rx_b_source_select_in ? rx_b_logic_input_in : rx_b_line_input_in))
		else $error("rx b source wrong");
	AST_RATE: assert property (
		$stable(rate_select_in)[*5] ##0 (uart_reset_n_out && $past(uart_reset_n_out, 3))
		|-> min_bit_cycles_out == (rate_select_in ? 8'h28 : 8'ha0))
		else $error("rate limit wrong");
	AST_DEPTH: assert property (
		uart_reset_n_out && $past(uart_reset_n_out) |-> fifo_depth_out == 7'h40)
		else $error("fifo depth wrong");
	AST_ISO: assert property (
		$stable({bus_isolate_request_in, sleep_mode_in})[*4] ##0 uart_reset_n_out
		|-> bus_isolated_out == (bus_isolate_request_in && sleep_mode_in))
		else $error("isolation state wrong");
	AST_WR_PASS: assert property (
		!bus_isolated_out && !$past(bus_isolated_out) && uart_reset_n_out &&
		$past(uart_reset_n_out) |-> host_wr_out == $past(host_wr_in))
		else $error("write strobe wrong");
	AST_RD_PASS: assert property (
		!bus_isolated_out && uart_reset_n_out && $past(uart_reset_n_out)
		|-> host_rd_out == $past(host_rd_in))
		else $error("read strobe wrong");
	AST_BUS_BLOCK: assert property (
		bus_isolated_out |-> !host_wr_out && !host_rd_out)
		else $error("strobe passed while isolated");
	cover property (!uart_reset_n_out ##1 uart_reset_n_out);
	cover property (bus_isolated_out && host_wr_in);
	cover property (host_wr_out);
	cover property (host_rd_out);
endmodule // dupc_props

/* File: tb/dupc_host_model.sv */
// dupc_host_model: host processor driving write strobes and the isolate pin
`timescale 1ns/100ps
module dupc_host_model (
	input wire logic core_clk_in,
	output logic wr_out,
	output logic rd_out,
	output logic [7:0] data_out,
	output logic iso_out
);
	initial begin
		{wr_out, rd_out, data_out, iso_out} = '0;
	end
	// one strobe cycle per byte; data is scrambled once the strobe drops
	task automatic put(input logic [7:0] b);
		@(negedge core_clk_in);
		wr_out = 1'b1;
		data_out = b;
		@(negedge core_clk_in);
		wr_out = 1'b0;
		data_out = ~b;
	endtask
	// one read strobe cycle
	task automatic get();
		@(negedge core_clk_in);
		rd_out = 1'b1;
		@(negedge core_clk_in);
		rd_out = 1'b0;
	endtask
	// high asks for bus isolation, low for normal access
	task automatic isolate(input logic v);
		@(negedge core_clk_in);
		iso_out = v;
	endtask
endmodule // dupc_host_model

/* File: tb/test_dupc_top.sv */
// test_dupc_top: directed bench for pin straps, reset and staging fifo
`timescale 1ns/100ps
module test_dupc_top;
	import dupc_pkg::*;
	logic core_clk_in, rst_n_in, bus_style_select_in, hw_reset_pin_in, rx_b_source_select_in;
	logic rx_b_logic_input_in, rx_b_line_input_in, rate_select_in, bus_isolate_request_in;
	logic sleep_mode_in, prescale_select_in, host_wr_in, host_rd_in, tx_a_internal_in;
	logic tx_b_internal_in, rx_stage_ready_in, bus_style_strobe_out, uart_reset_n_out;
	logic tx_a_line_output_out, tx_b_logic_output_out, tx_b_line_output_out, rx_b_selected_out;
	logic bus_isolated_out, host_wr_out, host_rd_out, wr_stage_ready_out, rx_stage_valid_out;
	logic baud_tick_out;
	logic [15:0] baud_div_in;
	logic [3:0] baud_frac_in;
	logic [7:0] host_wr_data_in, min_bit_cycles_out, rx_stage_data_out;
	logic [6:0] fifo_depth_out;
	int err_total = 0;
	int n_checks = 0;
	dupc_top u_dut (.*);
	dupc_host_model u_host (.core_clk_in, .wr_out(host_wr_in), .rd_out(host_rd_in),
		.data_out(host_wr_data_in), .iso_out(bus_isolate_request_in));
	// ----
	// helpers
	// ----
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task wcyc(input int n);
		repeat (n) @(negedge core_clk_in);
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ----
	// scenarios
	// ----
	task t_pinrst;
		int n;
		rx_b_line_input_in = 1'b0;
		for (int s = 1; s >= 0; s--) begin
			rst_n_in = 1'b0;
			bus_style_select_in = s[0];
			hw_reset_pin_in = ~s[0];
			wcyc(2);
			rst_n_in = 1'b1;
			wcyc(8);
			chk(bus_style_strobe_out, s[0]);
			hw_reset_pin_in = s[0];
			n = 0;
			while (uart_reset_n_out !== 1'b0 && n < 8) begin
				wcyc(1);
				n++;
			end
			chk(uart_reset_n_out, 1'b0);
			chk({rx_b_selected_out, tx_a_line_output_out, tx_b_logic_output_out}, 3'h7);
			// keep the pin active a while longer than the qualification needs
			wcyc(4);
			chk(uart_reset_n_out, 1'b0);
			hw_reset_pin_in = ~s[0];
			wcyc(8);
			chk({uart_reset_n_out, fifo_depth_out}, {1'b1, 7'h40});
		end
	endtask
	task t_straps;
		for (int i = 0; i < 4; i++) begin
			rx_b_source_select_in = i[1];
			rx_b_logic_input_in = i[0];
			rx_b_line_input_in = ~i[0];
			rate_select_in = i[0];
			tx_a_internal_in = i[0];
			tx_b_internal_in = i[1];
			wcyc(5);
			chk(rx_b_selected_out, i[1] ? i[0] : !i[0]);
			chk(min_bit_cycles_out, i[0] ? 8'h28 : 8'ha0);
			chk({tx_a_line_output_out, tx_b_logic_output_out, tx_b_line_output_out},
				{i[0], i[1], i[1]});
		end
	endtask
	task t_baud;
		int n;
		// divide by 1, divide by 4, then a half fraction over two periods (3 + 4)
		for (int p = 0; p < 3; p++) begin
			prescale_select_in = (p == 1);
			baud_frac_in = (p == 2) ? 4'h8 : 4'h0;
			wcyc(30);
			n = 0;
			while (baud_tick_out !== 1'b1 && n < 50) begin
				wcyc(1);
				n++;
			end
			n = 0;
			for (int k = 0; k < ((p == 2) ? 2 : 1); k++) begin
				do begin
					wcyc(1);
					n++;
				end while (baud_tick_out !== 1'b1 && n < 50);
			end
			chk(16'(n), (p == 1) ? 16'h000c : (p == 2) ? 16'h0007 : 16'h0003);
		end
	endtask
	task t_fifo;
		u_host.isolate(1'b1);
		wcyc(5);
		chk(bus_isolated_out, 1'b0);
		sleep_mode_in = 1'b1;
		wcyc(3);
		chk(bus_isolated_out, 1'b1);
		u_host.put(8'h5a);
		chk(host_wr_out, 1'b0);
		u_host.get();
		chk(host_rd_out, 1'b0);
		wcyc(3);
		chk(rx_stage_valid_out, 1'b0);
		u_host.isolate(1'b0);
		wcyc(5);
		u_host.get();
		chk(host_rd_out, 1'b1);
		// nine writes into eight words: the last is refused
		for (int i = 0; i < 9; i++) begin
			u_host.put(8'h10 + 8'(i));
			chk(host_wr_out, 1'b1);
		end
		chk(wr_stage_ready_out, 1'b0);
		for (int i = 0; i < 8; i++) begin
			wcyc(2);
			chk({rx_stage_valid_out, rx_stage_data_out}, {1'b1, 8'h10 + 8'(i)});
			rx_stage_ready_in = 1'b1;
			wcyc(1);
			rx_stage_ready_in = 1'b0;
		end
		wcyc(3);
		chk(rx_stage_valid_out, 1'b0);
	endtask
	// ----
	// sequence
	// ----
	initial begin
		core_clk_in = 1'b0;
		forever #12.5 core_clk_in = ~core_clk_in;
	end
	initial begin
		#100000;
		err_total++;
		close_out();
	end
	initial begin
		{rst_n_in, hw_reset_pin_in, rx_b_source_select_in, sleep_mode_in} = '0;
		{prescale_select_in, tx_a_internal_in, tx_b_internal_in, rx_stage_ready_in} = '0;
		{bus_style_select_in, rx_b_logic_input_in, rx_b_line_input_in, rate_select_in} = '1;
		baud_div_in = 16'h0003;
		baud_frac_in = 4'h0;
		wcyc(4);
		rst_n_in = 1'b1;
		wcyc(6);
		chk({tx_a_line_output_out, tx_b_line_output_out, fifo_depth_out}, 9'h040);
		$display("reset test done");
		t_pinrst();
		$display("pin reset test done");
		t_straps();
		$display("strap test done");
		t_baud();
		$display("baud test done");
		t_fifo();
		$display("fifo test done");
		close_out();
	end
endmodule // test_dupc_top
bind dupc_top dupc_props u_props (.*);
